// ### rtl/mmt_regs.svh
// Summary of operation
// - One 16-bit counter with a reload register
// - Four modes: interval, event, one-shot, PWM
// - Interval counts clock; pulse output toggles pin
// - Gate lets interval count at pin level
// - Event counts pin or overflows; free-run option
// - Two-phase up/down counting, normal or x4
// - One-shot starts on trigger, stops at zero
// - Trigger from pin edge, overflow or software
// - PWM: 16-bit fixed or 8-bit variable period
// - Clock is main /1, /8, /32 or sub /32
// - Interval and 8-bit PWM period is value plus one
// - Event period: value+1 down, FFFF-value+1 up
// - One-shot length equals value, no plus one
// - Period end flags an interrupt request
// - Pulse toggling drives pin, no port register
// - Counter read as one 16-bit word
// - Write while running updates reload only
// - Write while stopped loads reload and counter
// - Output pin is an input in two-phase event mode
// - Start flag runs counter; clearing holds value
// - Interval underflow reloads, continues, sets request
// - Gate counts while pin low or high
`ifndef MMT_REGS_SVH
`define MMT_REGS_SVH

`define MMT_OFF_CTRL      12'h000
`define MMT_OFF_TIMER     12'h004
`define MMT_OFF_TRIG      12'h008
`define MMT_OFF_STATUS    12'h00C

`define MMT_CTRL_RST      16'h0000
`define MMT_CNT_RST       16'h0000
`define MMT_CNT_MAX       16'hFFFF
`define MMT_CNT_ZERO      16'h0000
`define MMT_CNT_ONE       16'h0001
`define MMT_PWM16_LAST    16'hFFFE

`define MMT_DIV8_LAST     3'h7
`define MMT_DIV32_LAST    5'h1F
`define MMT_DIV_RST       5'h00

`define MMT_TRIG_SW_BIT   0
`define MMT_ST_REQ_BIT    0
`define MMT_ST_OUT_BIT    1
`define MMT_ST_RUN_BIT    2

`define MMT_SYNC_IN       0
`define MMT_SYNC_OUTPIN   1
`define MMT_SYNC_OVF      2
`define MMT_SYNC_SUB      3
`define MMT_SYNC_W        4

`endif

// ### rtl/mmt_pkg.sv
package mmt_pkg;

    typedef enum logic [1:0] {MMT_TIMER, MMT_EVENT, MMT_ONESHOT, MMT_PWM} mmt_mode_t;
    typedef enum logic [1:0] {MMT_GATE_OFF, MMT_GATE_RSV, MMT_GATE_LOW, MMT_GATE_HIGH} mmt_gate_t;
    typedef enum logic [1:0] {MMT_SRC_F1, MMT_SRC_F8, MMT_SRC_F32, MMT_SRC_SUB_CLOCK_DIV_THIRTY_TWO} mmt_src_t;
    typedef enum logic [1:0] {MMT_TRG_SW, MMT_TRG_PIN, MMT_TRG_OVF, MMT_TRG_RSV} mmt_trig_t;
    typedef enum logic {MMT_ST_IDLE, MMT_ST_RUN} mmt_run_t;

    typedef struct packed {
        logic      pwm8;
        mmt_trig_t trig;
        logic      up;
        logic      x4;
        logic      two_ph;
        logic      freerun;
        logic      ev_other;
        mmt_src_t  src;
        mmt_gate_t gate;
        logic      pulse;
        mmt_mode_t mode;
        logic      start;
    } mmt_ctrl_t;

endpackage

// ### rtl/mmt_timer.sv
`timescale 1ns/10ps
`include "mmt_regs.svh"

module mmt_timer
    import mmt_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Timer pins and events
    input  wire logic        i_timer_input_pin,
    input  wire logic        i_timer_output_pin_in,
    input  wire logic        i_sub_clk,
    input  wire logic        i_other_ovf,
    output logic             o_timer_output_pin_o,
    output logic             o_timer_output_pin_oe,
    output logic             o_ovf_pulse,
    output logic             o_irq_req
);

    logic [`MMT_SYNC_W-1:0] raw_in;
    logic [`MMT_SYNC_W-1:0] sync1_r;
    logic [`MMT_SYNC_W-1:0] sync2_r;
    logic [`MMT_SYNC_W-1:0] sync3_r;

    mmt_ctrl_t   ctrl_r;
    mmt_run_t    run_r;
    logic [15:0] reload_r;
    logic [15:0] cnt_r;
    logic [4:0]  div_r;
    logic [4:0]  sub_div_r;
    logic        out_r;
    logic        req_r;
    logic        ovf_r;
    logic [31:0] prdata_r;
    logic        slverr_r;

    logic        setup;
    logic        wr;
    logic        ctrl_wr;
    logic        timer_wr;
    logic        trig_wr;
    logic        stat_wr;
    logic        active;
    logic        tick8;
    logic        tick32;
    logic        sub_edge;
    logic        tick_sub_clock_div_thirty_two;
    logic        src_tick;
    logic        gate_ok;
    logic        a_lvl;
    logic        b_lvl;
    logic        a_edge;
    logic        b_edge;
    logic        a_rise;
    logic        ovf_rise;
    logic        ev_tick;
    logic        ev_up;
    logic        trig_evt;
    logic        trig_go;
    logic        ovf;
    logic [15:0] pwm_last;
    logic [15:0] pwm_width;
    logic        pwm_hi;

    // Input synchronisers
    assign raw_in = {i_sub_clk, i_other_ovf, i_timer_output_pin_in, i_timer_input_pin};

    genvar gi;
    generate
        for (gi = 0; gi < `MMT_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= raw_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                end
            end
        end
    endgenerate

    assign a_lvl    = sync2_r[`MMT_SYNC_IN];
    assign b_lvl    = sync2_r[`MMT_SYNC_OUTPIN];
    assign a_edge   = a_lvl ^ sync3_r[`MMT_SYNC_IN];
    assign b_edge   = b_lvl ^ sync3_r[`MMT_SYNC_OUTPIN];
    assign a_rise   = a_edge & a_lvl;
    assign ovf_rise = sync2_r[`MMT_SYNC_OVF] & ~sync3_r[`MMT_SYNC_OVF];
    assign sub_edge = sync2_r[`MMT_SYNC_SUB] & ~sync3_r[`MMT_SYNC_SUB];

    // Count clock dividers
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            div_r <= `MMT_DIV_RST;
        end else begin
            div_r <= div_r + 5'h01;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sub_div_r <= `MMT_DIV_RST;
        end else if (sub_edge) begin
            sub_div_r <= sub_div_r + 5'h01;
        end
    end

    assign tick8     = (div_r[2:0] == `MMT_DIV8_LAST);
    assign tick32    = (div_r == `MMT_DIV32_LAST);
    assign tick_sub_clock_div_thirty_two = sub_edge && (sub_div_r == `MMT_DIV32_LAST);

    always_comb begin
        unique case (ctrl_r.src)
            MMT_SRC_F1:   src_tick = 1'b1;
            MMT_SRC_F8:   src_tick = tick8;
            MMT_SRC_F32:  src_tick = tick32;
            MMT_SRC_SUB_CLOCK_DIV_THIRTY_TWO: src_tick = tick_sub_clock_div_thirty_two;
        endcase
    end

    // Gate: bit 1 enables, bit 0 picks the counting level
    assign gate_ok = ctrl_r.gate[1] ? (a_lvl == ctrl_r.gate[0]) : 1'b1;

    // Event source and direction
    always_comb begin
        if (ctrl_r.two_ph && ctrl_r.x4) begin
            ev_tick = a_edge ^ b_edge;
            ev_up   = a_edge ? (a_lvl != b_lvl) : (a_lvl == b_lvl);
        end else if (ctrl_r.two_ph) begin
            ev_tick = a_rise;
            ev_up   = b_lvl;
        end else begin
            ev_tick = ctrl_r.ev_other ? ovf_rise : a_rise;
            ev_up   = ctrl_r.up;
        end
    end

    // Trigger for one-shot and PWM
    always_comb begin
        unique case (ctrl_r.trig)
            MMT_TRG_SW:  trig_evt = trig_wr && i_pwdata[`MMT_TRIG_SW_BIT];
            MMT_TRG_PIN: trig_evt = a_rise;
            MMT_TRG_OVF: trig_evt = ovf_rise;
            MMT_TRG_RSV: trig_evt = 1'b0;
        endcase
    end

    assign trig_go = ctrl_r.start && (run_r == MMT_ST_IDLE) && trig_evt
                     && ((ctrl_r.mode == MMT_PWM)
                         || ((ctrl_r.mode == MMT_ONESHOT) && (reload_r != `MMT_CNT_ZERO)));

    // PWM shape
    assign pwm_last  = ctrl_r.pwm8 ? {8'h00, reload_r[7:0]} : `MMT_PWM16_LAST;
    assign pwm_width = ctrl_r.pwm8 ? {8'h00, reload_r[15:8]} : reload_r;
    assign pwm_hi    = (run_r == MMT_ST_RUN) && (cnt_r < pwm_width);

    // End of period
    always_comb begin
        unique case (ctrl_r.mode)
            MMT_TIMER:   ovf = ctrl_r.start && gate_ok && src_tick
                               && (cnt_r == `MMT_CNT_ZERO);
            MMT_EVENT:   ovf = ctrl_r.start && ev_tick
                               && (ev_up ? (cnt_r == `MMT_CNT_MAX)
                                         : (cnt_r == `MMT_CNT_ZERO));
            MMT_ONESHOT: ovf = (run_r == MMT_ST_RUN) && src_tick
                               && (cnt_r == `MMT_CNT_ONE);
            MMT_PWM:     ovf = (run_r == MMT_ST_RUN) && src_tick && (cnt_r == pwm_last);
        endcase
    end

    assign active = ctrl_r.start
                    && ((ctrl_r.mode == MMT_TIMER) || (ctrl_r.mode == MMT_EVENT)
                        || (run_r == MMT_ST_RUN));

    // APB decode
    assign setup    = i_psel && !i_penable;
    assign wr       = i_psel && i_penable && i_pwrite;
    assign ctrl_wr  = wr && (i_paddr == `MMT_OFF_CTRL) && (i_pstrb[1:0] == 2'b11);
    assign timer_wr = wr && (i_paddr == `MMT_OFF_TIMER) && (i_pstrb[1:0] == 2'b11);
    assign trig_wr  = wr && (i_paddr == `MMT_OFF_TRIG) && i_pstrb[0];
    assign stat_wr  = wr && (i_paddr == `MMT_OFF_STATUS) && i_pstrb[0];

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctrl_r <= mmt_ctrl_t'(`MMT_CTRL_RST);
        end else if (ctrl_wr) begin
            ctrl_r <= mmt_ctrl_t'(i_pwdata[15:0]);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            reload_r <= `MMT_CNT_RST;
        end else if (timer_wr) begin
            reload_r <= i_pwdata[15:0];
        end
    end

    // Run state for one-shot and PWM
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            run_r <= MMT_ST_IDLE;
        end else if (!ctrl_r.start || (ctrl_r.mode == MMT_TIMER)
                     || (ctrl_r.mode == MMT_EVENT)) begin
            run_r <= MMT_ST_IDLE;
        end else if (trig_go) begin
            run_r <= MMT_ST_RUN;
        end else if ((ctrl_r.mode == MMT_ONESHOT) && ovf) begin
            run_r <= MMT_ST_IDLE;
        end
    end

    // Counter
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            cnt_r <= `MMT_CNT_RST;
        end else if (timer_wr && !active) begin
            cnt_r <= i_pwdata[15:0];
        end else begin
            unique case (ctrl_r.mode)
                MMT_TIMER: begin
                    if (ctrl_r.start && gate_ok && src_tick) begin
                        cnt_r <= ovf ? reload_r : cnt_r - 16'h0001;
                    end
                end
                MMT_EVENT: begin
                    if (ctrl_r.start && ev_tick && ev_up) begin
                        if (ovf) begin
                            cnt_r <= ctrl_r.freerun ? `MMT_CNT_ZERO : reload_r;
                        end else begin
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end else if (ctrl_r.start && ev_tick) begin
                        if (ovf) begin
                            cnt_r <= ctrl_r.freerun ? `MMT_CNT_MAX : reload_r;
                        end else begin
                            cnt_r <= cnt_r - 16'h0001;
                        end
                    end
                end
                MMT_ONESHOT: begin
                    if (trig_go) begin
                        cnt_r <= reload_r;
                    end else if ((run_r == MMT_ST_RUN) && src_tick) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                MMT_PWM: begin
                    if (trig_go) begin
                        cnt_r <= `MMT_CNT_ZERO;
                    end else if ((run_r == MMT_ST_RUN) && src_tick) begin
                        cnt_r <= ovf ? `MMT_CNT_ZERO : cnt_r + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Pin output, kept apart from any port data register
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            out_r <= 1'b0;
        end else if (!ctrl_r.pulse) begin
            out_r <= 1'b0;
        end else begin
            unique case (ctrl_r.mode)
                MMT_TIMER:   out_r <= out_r ^ ovf;
                MMT_EVENT:   out_r <= out_r ^ ovf;
                MMT_ONESHOT: out_r <= trig_go || ((run_r == MMT_ST_RUN) && !ovf);
                MMT_PWM:     out_r <= pwm_hi;
            endcase
        end
    end

    assign o_timer_output_pin_o  = out_r;
    assign o_timer_output_pin_oe = ctrl_r.pulse
                                   && !((ctrl_r.mode == MMT_EVENT) && ctrl_r.two_ph);

    // Interrupt request flag; a new event beats the clear
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            req_r <= 1'b0;
        end else if (ovf) begin
            req_r <= 1'b1;
        end else if (stat_wr && i_pwdata[`MMT_ST_REQ_BIT]) begin
            req_r <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= ovf;
        end
    end

    assign o_irq_req   = req_r;
    assign o_ovf_pulse = ovf_r;

    // Read data and error captured in the setup cycle
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
            unique case (i_paddr)
                `MMT_OFF_CTRL: begin
                    prdata_r[15:0] <= ctrl_r;
                    slverr_r       <= i_pwrite && (i_pstrb[1:0] != 2'b11);
                end
                `MMT_OFF_TIMER: begin
                    prdata_r[15:0] <= cnt_r;
                    slverr_r       <= i_pwrite && (i_pstrb[1:0] != 2'b11);
                end
                `MMT_OFF_TRIG: begin
                    prdata_r <= 32'h0000_0000;
                end
                `MMT_OFF_STATUS: begin
                    prdata_r[`MMT_ST_REQ_BIT] <= req_r;
                    prdata_r[`MMT_ST_OUT_BIT] <= out_r;
                    prdata_r[`MMT_ST_RUN_BIT] <= active;
                end
                default: begin
                    slverr_r <= 1'b1;
                end
            endcase
        end
    end

    assign o_prdata  = prdata_r;
    assign o_pslverr = slverr_r;
    assign o_pready  = 1'b1;

endmodule

// ### verif/mmt_timer_props.sv
`timescale 1ns/10ps
`include "mmt_regs.svh"
module mmt_timer_props (
    // Clock, reset and bus
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Pins and events
    input wire logic        i_timer_input_pin,
    input wire logic        i_timer_output_pin_in,
    input wire logic        i_sub_clk,
    input wire logic        i_other_ovf,
    input wire logic        o_timer_output_pin_o,
    input wire logic        o_timer_output_pin_oe,
    input wire logic        o_ovf_pulse,
    input wire logic        o_irq_req
);
    logic clr;
    logic setup;
    assign clr = i_psel && i_penable && i_pwrite && i_paddr == `MMT_OFF_STATUS
        && i_pstrb[0] && i_pwdata[0];
    assign setup = i_psel && !i_penable;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    AST_READY: assert property (o_pready) else $error("pready low");
    AST_RST: assert property (disable iff (1'b0) i_sys_rst |=> !o_irq_req && !o_ovf_pulse
        && !o_timer_output_pin_o && !o_timer_output_pin_oe) else $error("reset state");
    AST_OVF_IRQ: assert property (o_ovf_pulse |-> o_irq_req) else $error("no request");
    AST_IRQ_HOLD: assert property (o_irq_req && !clr |=> o_irq_req)
        else $error("request lost");
    AST_IRQ_CLR: assert property (clr |=> o_irq_req == o_ovf_pulse)
        else $error("bad clear");
    AST_STRB: assert property (setup && i_pwrite && i_paddr == `MMT_OFF_TIMER
        && i_pstrb[1:0] != 2'b11 |=> o_pslverr) else $error("narrow write");
    AST_UPPER: assert property (setup && !i_pwrite && i_paddr == `MMT_OFF_TIMER
        |=> o_prdata[31:16] == 16'h0000 && !o_pslverr) else $error("upper bits");
    AST_RD_STAND: assert property (setup |=> ##1 $stable(o_prdata))
        else $error("read data moved");
endmodule

bind mmt_timer mmt_timer_props mmt_timer_props_inst (.i_mclk, .i_sys_rst, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr,
    .i_timer_input_pin, .i_timer_output_pin_in, .i_sub_clk, .i_other_ovf,
    .o_timer_output_pin_o, .o_timer_output_pin_oe, .o_ovf_pulse, .o_irq_req);

// ### verif/mmt_pins_model.sv
`timescale 1ns/10ps
module mmt_pins_model (
    // Pin side of the timer
    input  wire logic i_mclk,
    input  wire logic i_pin_o,
    input  wire logic i_pin_oe,
    output logic      o_in_pin,
    output logic      o_pin_in,
    output logic      o_sub_clk,
    output logic      o_other_ovf
);
    logic lvl;
    logic last;
    logic phb;
    logic phb_on;
    initial begin
        lvl = 1'b0;
        last = 1'b0;
        phb = 1'b0;
        phb_on = 1'b0;
        o_other_ovf = 1'b0;
        o_sub_clk = 1'b0;
        forever #100 o_sub_clk = ~o_sub_clk;
    end
    // Released pin: outside phase B if driven, else inverse of last level
    always @(posedge i_mclk) if (i_pin_oe) last <= i_pin_o;
    assign o_pin_in = i_pin_oe ? i_pin_o : (phb_on ? phb : ~last);
    assign o_in_pin = lvl;
    task pulses(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            lvl <= 1'b1;
            repeat (4) @(posedge i_mclk);
            lvl <= 1'b0;
            repeat (4) @(posedge i_mclk);
        end
    endtask
endmodule

// ### verif/multi_mode_16bit_timer_tb.sv
`timescale 1ns/10ps
`include "mmt_regs.svh"
module multi_mode_16bit_timer_tb;
    localparam logic [11:0] CT = `MMT_OFF_CTRL;
    localparam logic [11:0] TM = `MMT_OFF_TIMER;
    localparam logic [11:0] TG = `MMT_OFF_TRIG;
    localparam logic [11:0] ST = `MMT_OFF_STATUS;
    logic        i_mclk, i_sys_rst, i_psel, i_penable, i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, q, h;
    logic [3:0]  i_pstrb;
    logic        o_pready, o_pslverr, e, in_pin, pin_in, sub_clk, other_ovf;
    logic        o_timer_output_pin_o, o_timer_output_pin_oe, o_ovf_pulse, o_irq_req;
    int          fail_count, check_count, c, t;
    int          dv [4] = '{1, 8, 32, 256};
    logic [31:0] ev_rl [2] = '{32'h0000_0003, 32'h0000_FFFD};
    logic [31:0] ev_ct [2] = '{32'h0000_0003, 32'h0000_1003};
    int          ev_n [2] = '{4, 3};

    mmt_timer mmt_timer_inst (.i_mclk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_timer_input_pin(in_pin),
        .i_timer_output_pin_in(pin_in), .i_sub_clk(sub_clk), .i_other_ovf(other_ovf),
        .o_timer_output_pin_o, .o_timer_output_pin_oe, .o_ovf_pulse, .o_irq_req);
    mmt_pins_model mmt_pins_model_inst (.i_mclk, .i_pin_o(o_timer_output_pin_o),
        .i_pin_oe(o_timer_output_pin_oe), .o_in_pin(in_pin), .o_pin_in(pin_in),
        .o_sub_clk(sub_clk), .o_other_ovf(other_ovf));

    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        do @(posedge i_mclk); while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // Length of one full period and pin change across it
    task gap;
        logic p;
        c = 0;
        @(negedge i_mclk iff o_ovf_pulse === 1'b1);
        p = o_timer_output_pin_o;
        do begin
            @(negedge i_mclk);
            c++;
        end while (o_ovf_pulse !== 1'b1);
        t = p ^ o_timer_output_pin_o;
    endtask
    task wrap_up;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        wrap_up;
    end
    initial begin
        {i_sys_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {1'b1, 47'h0};
        {fail_count, check_count, i_pstrb} = {64'h0, 4'hF};
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        apb(CT, 0, 0);
        chk(q, 0);
        apb(TM, 0, 0);
        chk(q, 0);
        apb(ST, 0, 0);
        chk(q, 0);
        apb(12'h010, 0, 0);
        chk(e, 1);
        apb(TM, 1, 5);
        apb(TM, 0, 0);
        chk(q, 5);
        i_pstrb <= 4'h1;
        apb(TM, 1, 9);
        chk(e, 1);
        i_pstrb <= 4'hF;
        apb(TM, 0, 0);
        chk(q, 5);
        for (int s = 0; s < 4; s++) begin
            apb(CT, 1, 0);
            apb(TM, 1, 1);
            apb(CT, 1, 9 | (s << 6));
            gap;
            chk(c, 2 * dv[s]);
            chk(t, 1);
        end
        @(negedge i_mclk);
        chk(o_timer_output_pin_oe, 1);
        apb(CT, 1, 0);
        apb(TM, 1, 1);
        apb(CT, 1, 9);
        apb(TM, 1, 4);
        gap;
        gap;
        chk(c, 5);
        apb(CT, 1, 0);
        apb(TM, 0, 0);
        h = q;
        repeat (10) @(negedge i_mclk);
        apb(TM, 0, 0);
        chk(q, h);
        apb(ST, 0, 0);
        chk(q[0], 1);
        apb(ST, 1, 1);
        apb(ST, 0, 0);
        chk(q[0], 0);
        mmt_pins_model_inst.lvl <= 1'b1;
        apb(TM, 1, 32'h0000_0100);
        apb(CT, 1, 32'h0000_0021);
        repeat (20) @(negedge i_mclk);
        apb(TM, 0, 0);
        chk(q, 32'h0000_0100);
        mmt_pins_model_inst.lvl <= 1'b0;
        repeat (20) @(negedge i_mclk);
        apb(TM, 0, 0);
        chk(q < 32'h0000_0100, 1);
        for (int i = 0; i < 2; i++) begin
            apb(CT, 1, 0);
            apb(ST, 1, 1);
            apb(TM, 1, ev_rl[i]);
            apb(CT, 1, ev_ct[i]);
            mmt_pins_model_inst.pulses(ev_n[i] - 1);
            apb(ST, 0, 0);
            chk(q[0], 0);
            mmt_pins_model_inst.pulses(1);
            apb(ST, 0, 0);
            chk(q[0], 1);
        end
        // Free-run underflow wraps instead of reloading
        apb(CT, 1, 0);
        apb(TM, 1, 1);
        apb(CT, 1, 32'h0000_0203);
        mmt_pins_model_inst.pulses(2);
        apb(TM, 0, 0);
        chk(q, 32'h0000_FFFF);
        // Two-phase normal: phase B level picks the direction
        mmt_pins_model_inst.phb_on <= 1'b1;
        mmt_pins_model_inst.phb <= 1'b1;
        apb(CT, 1, 0);
        apb(TM, 1, 5);
        apb(CT, 1, 32'h0000_040B);
        @(negedge i_mclk);
        chk(o_timer_output_pin_oe, 0);
        mmt_pins_model_inst.pulses(2);
        mmt_pins_model_inst.phb <= 1'b0;
        mmt_pins_model_inst.pulses(1);
        apb(TM, 0, 0);
        chk(q, 6);
        mmt_pins_model_inst.phb_on <= 1'b0;
        // Eight-bit PWM: period 4, high 2
        apb(CT, 1, 0);
        apb(TM, 1, 32'h0000_0203);
        apb(CT, 1, 32'h0000_800F);
        apb(TG, 1, 1);
        gap;
        chk(c, 4);
        c = 0;
        repeat (8) begin
            @(negedge i_mclk);
            c += (o_timer_output_pin_o === 1'b1);
        end
        chk(c, 4);
        apb(CT, 1, 0);
        apb(ST, 1, 1);
        apb(TM, 1, 5);
        apb(CT, 1, 32'h0000_000D);
        apb(TG, 1, 1);
        c = 0;
        repeat (40) begin
            @(negedge i_mclk);
            c += (o_timer_output_pin_o === 1'b1);
        end
        chk(c, 5);
        chk(o_irq_req, 1);
        apb(ST, 0, 0);
        chk(q[0], 1);
        wrap_up;
    end
endmodule
